//--- src/dual_coil_phase_pwm.sv
/*
 * Four chained timers producing two half period shifted PWM pairs for two coils.
 * Assumes all controls come from logic on sys_clk and that software keeps
 * the offset and duty within one period.
 */
`timescale 1ns/10ps

//Behaviour
//- Two output pairs, positive and negative line, for coil zero and coil one.
//- Negative line of each pair trails the positive line by half a period.
//- Pair to pair offset is programmable between minus and plus a quarter period.
//- Each pair has one duty setting from zero to full, shared by both lines.
//- Controller timer has three compare channels, the others two.
//- A compare channel drives a PWM line or a delayed event trigger.
//- Each timer has two publisher ports and one subscriber port.
//- Timers coordinate only through a one publisher, one subscriber channel.
//- Event channel latency is a fixed number of cycles.
//- Trigger compare values are reduced by the fixed event latency plus two cycles.
//- Every line comes from a timer; each target is started by an event from the controller or an earlier timer.
//- Controller mode uses one three channel timer and three two channel timers.
//- Serial mode uses four two channel timers, each starting the next.
//- In controller mode, controller channel one sets the offset between the two coil pairs.
//- Controller channel two (channel one in serial mode) sets the half period offset inside coil zero pair.
//- First coil one timer channel one sets the half period inside coil one pair.
//- Channel zero of both coil zero timers sets the coil zero duty.
//- Channel zero of both coil one timers sets the coil one duty.
//- The load value sets the period of all outputs.
module dual_coil_phase_pwm
#(
    parameter int CNT_W = 16
)
(
    input  wire logic                        sys_clk,
    input  wire logic                        reset_n,
    input  wire logic                        enable,
    input  wire dual_coil_pkg::chain_mode_t  chainMode,
    input  wire logic [CNT_W-1:0]            loadValue,
    input  wire logic [CNT_W-1:0]            coil0Duty,
    input  wire logic [CNT_W-1:0]            coil1Duty,
    input  wire logic signed [CNT_W-1:0]     pairPhaseOffset,
    output      logic                        coil0PosOut,
    output      logic                        coil0NegOut,
    output      logic                        coil1PosOut,
    output      logic                        coil1NegOut,
    output      logic [3:0]                  timerRunning,
    output      logic [7:0]                  publisherEvents
);
    localparam int NT      = dual_coil_pkg::NUM_TIMERS;
    localparam int WX      = CNT_W + 2;
    localparam int EVT_DLY = dual_coil_pkg::EVT_LAT_CYC;

    typedef logic signed [WX-1:0] wide_t;

    if (CNT_W < 4 || CNT_W > 30)
    begin : g_width_check
        $error("CNT_W must lie between 4 and 30");
    end
    if (EVT_DLY < 1)
    begin : g_lat_check
        $error("Event latency must be at least one cycle");
    end

    // Folds a value back into one period
    function automatic wide_t wrapPeriod(input wide_t x, input wide_t period);
        wide_t y;
        y = x;
        if (y < 0)
            y = y + period;
        if (y >= period)
            y = y - period;
        if (y < 0)
            y = '0;
        return y;
    endfunction

    // Compare value that starts a target at the given phase
    function automatic logic [CNT_W-1:0] trigValue(input wide_t phase, input wide_t period);
        wide_t y;
        y = wrapPeriod(phase - wide_t'(dual_coil_pkg::EVENT_CORRECTION), period);
        return y[CNT_W-1:0];
    endfunction

    logic                         enableQ;
    logic                         startPulse;
    logic [NT-1:0]                subEvt;
    logic [NT-2:0]                chanSrc;
    logic [NT-2:0][EVT_DLY-1:0]   chanPipeQ;
    logic [NT-1:0]                runQ;
    logic [NT-1:0][CNT_W-1:0]     cntQ;
    logic [NT-1:0][CNT_W-1:0]     loadQ;
    logic [NT-1:0][CNT_W-1:0]     cc0Q;
    logic [NT-1:0][CNT_W-1:0]     cc1Q;
    logic [NT-1:0][CNT_W-1:0]     cc2Q;
    logic [NT-1:0][1:0]           pubQ;
    logic [NT-1:0]                pwmQ;
    logic [NT-1:0][CNT_W-1:0]     cc0In;
    logic [NT-1:0][CNT_W-1:0]     cc1In;
    logic [NT-1:0][CNT_W-1:0]     cc2In;
    logic [NT-1:0]                pub1Allowed;
    wide_t                        period;
    wide_t                        quarter;
    wide_t                        offClamped;
    wide_t                        pairCmp;
    wide_t                        coil0InnerPhase;
    wide_t                        coil1InnerPhase;
    wide_t                        serialLink;

    // Phase arithmetic from the programmed period
    always_comb
    begin
        period          = wide_t'({1'b0, loadValue}) + wide_t'(1);
        quarter         = period >>> 2;
        coil0InnerPhase = period >>> 1;
        coil1InnerPhase = period >>> 1;
        offClamped      = wide_t'(pairPhaseOffset);
        if (offClamped > quarter)
            offClamped = quarter;
        if (offClamped < -quarter)
            offClamped = -quarter;
        pairCmp         = wrapPeriod(offClamped, period);
        serialLink      = wrapPeriod(pairCmp - coil0InnerPhase, period);
    end

    // Compare channel assignment per chain mode
    always_comb
    begin
        cc0In[dual_coil_pkg::TMR_CONTROLLER]   = coil0Duty;
        cc0In[dual_coil_pkg::TMR_COIL0_SECOND] = coil0Duty;
        cc0In[dual_coil_pkg::TMR_COIL1_FIRST]  = coil1Duty;
        cc0In[dual_coil_pkg::TMR_COIL1_SECOND] = coil1Duty;
        cc1In       = '0;
        cc2In       = '0;
        pub1Allowed = '0;
        cc1In[dual_coil_pkg::TMR_COIL1_FIRST] = trigValue(coil1InnerPhase, period);
        if (chainMode == dual_coil_pkg::CHAIN_CONTROLLER)
        begin
            cc1In[dual_coil_pkg::TMR_CONTROLLER] = trigValue(pairCmp, period);
            cc2In[dual_coil_pkg::TMR_CONTROLLER] = trigValue(coil0InnerPhase, period);
            pub1Allowed[dual_coil_pkg::TMR_CONTROLLER] = 1'b1;
        end
        else
        begin
            cc1In[dual_coil_pkg::TMR_CONTROLLER]   = trigValue(coil0InnerPhase, period);
            cc1In[dual_coil_pkg::TMR_COIL0_SECOND] = trigValue(serialLink, period);
        end
    end

    // Start event for the controller
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            enableQ <= dual_coil_pkg::RST_LEVEL;
        else
            enableQ <= enable;
    end

    assign startPulse = enable & ~enableQ;

    // Channel sources: channel k feeds the subscriber of timer k plus one
    always_comb
    begin
        if (chainMode == dual_coil_pkg::CHAIN_CONTROLLER)
        begin
            chanSrc[0] = pubQ[dual_coil_pkg::TMR_CONTROLLER][1];
            chanSrc[1] = pubQ[dual_coil_pkg::TMR_CONTROLLER][0];
        end
        else
        begin
            chanSrc[0] = pubQ[dual_coil_pkg::TMR_CONTROLLER][0];
            chanSrc[1] = pubQ[dual_coil_pkg::TMR_COIL0_SECOND][0];
        end
        chanSrc[2] = pubQ[dual_coil_pkg::TMR_COIL1_FIRST][0];
    end

    // Fixed latency event channels
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            chanPipeQ <= '0;
        else if (!enable)
            chanPipeQ <= '0;
        else
            for (int k = 0; k < NT - 1; k++)
                chanPipeQ[k] <= EVT_DLY'({chanPipeQ[k], chanSrc[k]});
    end

    assign subEvt[0] = startPulse;
    for (genvar k = 0; k < NT - 1; k++)
    begin : g_sub
        assign subEvt[k+1] = chanPipeQ[k][EVT_DLY-1];
    end

    for (genvar i = 0; i < NT; i++)
    begin : g_timer
        logic boundary;
        assign boundary = !runQ[i] || (cntQ[i] == loadQ[i]);

        // Subscriber start and period counter
        always_ff @(posedge sys_clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                runQ[i] <= dual_coil_pkg::RST_LEVEL;
                cntQ[i] <= '0;
            end
            else if (!enable)
            begin
                runQ[i] <= 1'b0;
                cntQ[i] <= '0;
            end
            else if (!runQ[i])
            begin
                if (subEvt[i])
                begin
                    runQ[i] <= 1'b1;
                    cntQ[i] <= '0;
                end
            end
            else if (cntQ[i] == loadQ[i])
                cntQ[i] <= '0;
            else
                cntQ[i] <= cntQ[i] + 1'b1;
        end

        // Shadow values, taken while the timer is stopped and at the period boundary only
        always_ff @(posedge sys_clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                loadQ[i] <= '0;
                cc0Q[i]  <= '0;
                cc1Q[i]  <= '0;
                cc2Q[i]  <= '0;
            end
            else if (boundary)
            begin
                loadQ[i] <= loadValue;
                cc0Q[i]  <= cc0In[i];
                cc1Q[i]  <= cc1In[i];
                cc2Q[i]  <= cc2In[i];
            end
        end

        // Channel zero as PWM line, channels one and two as publishers
        always_ff @(posedge sys_clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                pwmQ[i] <= dual_coil_pkg::RST_LEVEL;
                pubQ[i] <= '0;
            end
            else
            begin
                pwmQ[i]    <= runQ[i] && enable
                              && ((cntQ[i] < cc0Q[i]) || (cc0Q[i] > loadQ[i]));
                pubQ[i][0] <= runQ[i] && enable && (cntQ[i] == cc1Q[i]);
                pubQ[i][1] <= runQ[i] && enable && pub1Allowed[i]
                              && (cntQ[i] == cc2Q[i]);
            end
        end

        property p_period_wrap;
            @(posedge sys_clk) disable iff (!reset_n)
            runQ[i] && enable && (cntQ[i] == loadQ[i]) |=> cntQ[i] == '0;
        endproperty
        a_period_wrap: assert property (p_period_wrap)
            else $error("Counter did not wrap at load value");

        property p_shadow_hold;
            @(posedge sys_clk) disable iff (!reset_n)
            runQ[i] && enable && (cntQ[i] != loadQ[i])
                |=> $stable(loadQ[i]) && $stable(cc0Q[i]) && $stable(cc1Q[i]);
        endproperty
        a_shadow_hold: assert property (p_shadow_hold)
            else $error("Shadow value changed inside a period");

        property p_zero_duty;
            @(posedge sys_clk) disable iff (!reset_n)
            runQ[i] && (cc0Q[i] == '0) |=> !pwmQ[i];
        endproperty
        a_zero_duty: assert property (p_zero_duty)
            else $error("Output high with zero duty");

        property p_full_duty;
            @(posedge sys_clk) disable iff (!reset_n)
            runQ[i] && enable && (cc0Q[i] > loadQ[i]) |=> pwmQ[i];
        endproperty
        a_full_duty: assert property (p_full_duty)
            else $error("Output low with full duty");

        property p_run_holds;
            @(posedge sys_clk) disable iff (!reset_n)
            runQ[i] && enable |=> runQ[i];
        endproperty
        a_run_holds: assert property (p_run_holds)
            else $error("Running timer stopped while enabled");
    end

    assign coil0PosOut     = pwmQ[dual_coil_pkg::TMR_CONTROLLER];
    assign coil0NegOut     = pwmQ[dual_coil_pkg::TMR_COIL0_SECOND];
    assign coil1PosOut     = pwmQ[dual_coil_pkg::TMR_COIL1_FIRST];
    assign coil1NegOut     = pwmQ[dual_coil_pkg::TMR_COIL1_SECOND];
    assign timerRunning    = runQ;
    assign publisherEvents = pubQ;

    property p_idle_low;
        @(posedge sys_clk) disable iff (!reset_n)
        !enable |=> ##1 !(coil0PosOut || coil0NegOut || coil1PosOut || coil1NegOut);
    endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("Outputs active while disabled");

    property p_start_runs;
        @(posedge sys_clk) disable iff (!reset_n)
        startPulse |=> runQ[dual_coil_pkg::TMR_CONTROLLER];
    endproperty
    a_start_runs: assert property (p_start_runs)
        else $error("Controller did not start on enable");

    property p_chain_delay;
        @(posedge sys_clk) disable iff (!reset_n)
        enable && chanSrc[1] ##1 enable [*1] |-> ##(EVT_DLY - 1) subEvt[2];
    endproperty
    a_chain_delay: assert property (p_chain_delay)
        else $error("Event channel latency differs from the fixed value");

    property p_inner_phase;
        @(posedge sys_clk) disable iff (!reset_n)
        enable && (chainMode == dual_coil_pkg::CHAIN_CONTROLLER)
            && $rose(runQ[dual_coil_pkg::TMR_COIL0_SECOND])
            && $stable(loadQ[dual_coil_pkg::TMR_CONTROLLER])
            |-> wide_t'({1'b0, cntQ[dual_coil_pkg::TMR_CONTROLLER]})
                == wrapPeriod(wide_t'({1'b0, cc2Q[dual_coil_pkg::TMR_CONTROLLER]})
                    + wide_t'(dual_coil_pkg::EVENT_CORRECTION),
                    wide_t'({1'b0, loadQ[dual_coil_pkg::TMR_CONTROLLER]}) + wide_t'(1));
    endproperty
    a_inner_phase: assert property (p_inner_phase)
        else $error("Coil zero negative line started at the wrong phase");

endmodule

//--- src/dual_coil_pkg.sv
/*
 * Shared constants for the dual coil phase PWM block: timer roles,
 * chain modes and event timing.
 * Assumes a single 20 MHz system clock drives every timer of the chain.
 */
package dual_coil_pkg;

    // Timer roles, by index in the chain
    localparam int TMR_CONTROLLER   = 0;
    localparam int TMR_COIL0_SECOND = 1;
    localparam int TMR_COIL1_FIRST  = 2;
    localparam int TMR_COIL1_SECOND = 3;
    localparam int NUM_TIMERS       = 4;
    localparam int PUB_PER_TIMER    = 2;

    // Clock and event channel timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int EVT_LAT_NS    = 100;
    localparam int EVT_LAT_CYC   = (EVT_LAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Publisher flop plus target start flop add two cycles to the channel
    localparam int EVENT_CORRECTION = EVT_LAT_CYC + 2;

    // Reset values
    localparam logic RST_LEVEL = 1'b0;

    typedef enum logic
    {
        CHAIN_CONTROLLER,
        CHAIN_SERIAL
    } chain_mode_t;

endpackage

//--- testbench/coil_driver_model.sv
/*
 * Coil driver stand-in: takes the four PWM lines and measures each one.
 * Assumes the lines change only just after rising edges of sys_clk.
 */
`timescale 1ns/10ps
module coil_driver_model
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic coil0PosOut,
    input wire logic coil0NegOut,
    input wire logic coil1PosOut,
    input wire logic coil1NegOut
);
    logic [3:0] lineNow;
    logic [3:0] lineQ;
    int         cyc;
    int         riseAt [4];
    int         highLen [4];
    int         period [4];
    int         rises [4];

    assign lineNow = {coil1NegOut, coil1PosOut, coil0NegOut, coil0PosOut};

    // Rise time, period and high time of each line
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lineQ <= 4'h0;
            cyc <= 0;
        end
        else
        begin
            cyc <= cyc + 1;
            lineQ <= lineNow;
            for (int i = 0; i < 4; i++)
            begin
                if (lineNow[i] && !lineQ[i])
                begin
                    period[i] <= cyc - riseAt[i];
                    riseAt[i] <= cyc;
                    rises[i] <= rises[i] + 1;
                end
                if (!lineNow[i] && lineQ[i])
                    highLen[i] <= cyc - riseAt[i];
            end
        end
    end
endmodule

//--- testbench/dual_coil_phase_pwm_tb.sv
/*
 * Bench for dual_coil_phase_pwm: settings table in both chain modes, then
 * duty limits, mid-period change, stop and reset. Assumes coil_driver_model.
 */
`timescale 1ns/10ps
module dual_coil_phase_pwm_tb;
    typedef struct
    {
        dual_coil_pkg::chain_mode_t mode;
        int                         load;
        int                         d0;
        int                         d1;
        int                         off;
    } row_t;
    localparam dual_coil_pkg::chain_mode_t CTL = dual_coil_pkg::CHAIN_CONTROLLER;
    localparam dual_coil_pkg::chain_mode_t SER = dual_coil_pkg::CHAIN_SERIAL;

    logic                       sys_clk;
    logic                       reset_n;
    logic                       enable;
    dual_coil_pkg::chain_mode_t chainMode;
    logic [15:0]                loadValue;
    logic [15:0]                coil0Duty;
    logic [15:0]                coil1Duty;
    logic signed [15:0]         pairPhaseOffset;
    logic                       coil0PosOut;
    logic                       coil0NegOut;
    logic                       coil1PosOut;
    logic                       coil1NegOut;
    logic [3:0]                 timerRunning;
    logic [7:0]                 publisherEvents;
    logic [7:0]                 seenEvt;
    logic [3:0]                 lines;
    int                         failures;
    int                         total_checks;
    int                         p;
    int                         k;
    int                         hi;
    row_t                       rows [8];

    assign lines = {coil1NegOut, coil1PosOut, coil0NegOut, coil0PosOut};

    dual_coil_phase_pwm #(.CNT_W(16)) i_dut
    (
        .sys_clk(sys_clk), .reset_n(reset_n), .enable(enable), .chainMode(chainMode),
        .loadValue(loadValue), .coil0Duty(coil0Duty), .coil1Duty(coil1Duty),
        .pairPhaseOffset(pairPhaseOffset), .coil0PosOut(coil0PosOut),
        .coil0NegOut(coil0NegOut), .coil1PosOut(coil1PosOut), .coil1NegOut(coil1NegOut),
        .timerRunning(timerRunning), .publisherEvents(publisherEvents)
    );

    coil_driver_model i_model
    (
        .sys_clk(sys_clk), .reset_n(reset_n), .coil0PosOut(coil0PosOut),
        .coil0NegOut(coil0NegOut), .coil1PosOut(coil1PosOut), .coil1NegOut(coil1NegOut)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Publisher pulses seen since the last enable
    always @(posedge sys_clk)
        seenEvt <= enable ? (seenEvt | publisherEvents) : 8'h00;

    function automatic int md(input int a, input int m);
        return ((a % m) + m) % m;
    endfunction

    function automatic int clampOff(input int o, input int m);
        int q;
        q = m >>> 2;
        return (o > q) ? q : ((o < -q) ? -q : o);
    endfunction

    task automatic conclude();
        if (failures == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step();
        @(negedge sys_clk);
        k++;
        if (k > 3000)
        begin
            failures++;
            conclude();
        end
    endtask

    task automatic start(input row_t r);
        enable = 1'b0;
        repeat (2) @(negedge sys_clk);
        chainMode = r.mode;
        loadValue = r.load[15:0];
        coil0Duty = r.d0[15:0];
        coil1Duty = r.d1[15:0];
        pairPhaseOffset = r.off[15:0];
        @(negedge sys_clk);
        enable = 1'b1;
        p = r.load + 1;
        k = 0;
    endtask

    initial
    begin
        rows = '{'{CTL, 19, 5, 10, 0}, '{CTL, 19, 1, 19, 5}, '{CTL, 39, 20, 7, -10},
                 '{CTL, 39, 13, 30, 30}, '{CTL, 24, 12, 3, -6}, '{SER, 19, 5, 10, 0},
                 '{SER, 39, 20, 7, -10}, '{SER, 24, 12, 3, -30}};
        failures = 0;
        total_checks = 0;
        reset_n = 1'b0;
        enable = 1'b0;
        chainMode = CTL;
        loadValue = 16'h0013;
        coil0Duty = 16'h0005;
        coil1Duty = 16'h0005;
        pairPhaseOffset = 16'h0000;
        repeat (12) @(negedge sys_clk);
        chk(lines, 4'h0);
        reset_n = 1'b1;
        foreach (rows[i])
        begin
            start(rows[i]);
            hi = i_model.rises[3] + 4;
            while (i_model.rises[3] < hi)
                step();
            chk(i_model.period[0], p);
            chk(i_model.period[3], p);
            chk(i_model.highLen[0], rows[i].d0);
            chk(i_model.highLen[1], rows[i].d0);
            chk(i_model.highLen[2], rows[i].d1);
            chk(i_model.highLen[3], rows[i].d1);
            chk(md(i_model.riseAt[1] - i_model.riseAt[0], p), p >> 1);
            chk(md(i_model.riseAt[3] - i_model.riseAt[2], p), p >> 1);
            chk(md(i_model.riseAt[2] - i_model.riseAt[0], p), md(clampOff(rows[i].off, p), p));
            chk(timerRunning, 4'hf);
            if (rows[i].mode == CTL)
                chk(seenEvt[1:0], 2'b11);
            else
                chk({seenEvt[4], seenEvt[2], seenEvt[0]}, 3'b111);
        end
        // Duty zero and above the load: lines stay at one level
        start('{CTL, 19, 0, 20, 0});
        while (timerRunning !== 4'hf)
            step();
        repeat (4) @(negedge sys_clk);
        repeat (40)
        begin
            @(negedge sys_clk);
            chk(lines, 4'b1100);
        end
        // Duty raised inside a pulse: only whole old or new pulses
        start('{CTL, 19, 5, 10, 0});
        while (coil0PosOut !== 1'b1)
            step();
        coil0Duty = 16'h000f;
        hi = 0;
        while (coil0PosOut === 1'b1)
        begin
            hi++;
            step();
        end
        chk(hi, 5);
        hi = 0;
        repeat (80)
        begin
            @(negedge sys_clk);
            if (coil0PosOut === 1'b1)
                hi++;
            else if (hi > 0)
            begin
                chk(hi, 15);
                hi = 0;
            end
        end
        chk(i_model.highLen[0], 15);
        // Stop clears every timer and line
        enable = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(timerRunning, 4'h0);
        chk(lines, 4'h0);
        // Reset in mid-run
        start('{SER, 19, 5, 10, 0});
        repeat (60) @(negedge sys_clk);
        reset_n = 1'b0;
        #1;
        chk({timerRunning, lines, publisherEvents}, 16'h0000);
        @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        chk({timerRunning, lines}, 8'h10);
        @(negedge sys_clk);
        chk({timerRunning, lines}, 8'h11);
        k = 0;
        hi = i_model.rises[3] + 2;
        while (i_model.rises[3] < hi)
            step();
        chk(i_model.period[3], 20);
        chk(md(i_model.riseAt[3] - i_model.riseAt[0], 20), 10);
        conclude();
    end
endmodule
